// ==== core/bsp_drive_if.sv ====
// drive settings passed from the sequencer to each bridge leg
interface bsp_drive_if;
	logic [2:0] sector;
	logic [7:0] angle;
	logic [7:0] duty;
	logic [8:0] car_cnt;
	logic [8:0] car_period;
	logic       sine_mode;
	logic       drive_en;
	logic       reverse;
	modport source (output sector, angle, duty, car_cnt, car_period,
		sine_mode, drive_en, reverse);
	modport sink (input sector, angle, duty, car_cnt, car_period,
		sine_mode, drive_en, reverse);
endinterface

// ==== core/bsp_phase_gen.sv ====
// one bridge leg: block commutation or sine pwm for a single phase
module bsp_phase_gen
	import bsp_pkg::*;
#(
	parameter int unsigned PHASE = 0
)
(
	input  wire logic  clk_in,
	input  wire logic  rst_n_in,
	bsp_drive_if.sink  drv,
	output logic       hi_out,
	output logic       lo_out
);
	localparam logic [6:0] SIN_Q [16] = '{7'h06, 7'h12, 7'h1e, 7'h29,
		7'h34, 7'h3f, 7'h49, 7'h53, 7'h5c, 7'h64, 7'h6b, 7'h71, 7'h76,
		7'h7a, 7'h7d, 7'h7f};
	logic [2:0]  rel;
	logic [7:0]  ang;
	logic [3:0]  idx;
	logic [7:0]  lvl;
	logic [15:0] prod;
	logic        on_sine;
	logic        on_blk;
	logic        hi_nxt;
	logic        lo_nxt;

	always_comb
	begin
		// sector relative to this leg; reverse swaps high and low pairs
		rel = 3'((32'(drv.sector) + 6 + (drv.reverse ? 3 : 0)
			- 2 * PHASE) % 6);
		ang = drv.angle - 8'(PHASE * PHASE_ANG)
			+ (drv.reverse ? 8'h80 : 8'h00);
		idx = ang[6] ? ~ang[5:2] : ang[5:2];
		lvl = ang[7] ? 8'(8'h7f - {1'b0, SIN_Q[idx]})
			: 8'(8'h7f + {1'b0, SIN_Q[idx]});
		prod = 16'(lvl * drv.duty);
		on_sine = (18'(drv.car_cnt) << 8)
			< 18'(32'(prod[15:7]) * 32'(drv.car_period));
		on_blk = (18'(drv.car_cnt) << 7)
			< 18'(32'(drv.duty) * 32'(drv.car_period));
		hi_nxt = 1'b0;
		lo_nxt = 1'b0;
		if (drv.drive_en && drv.sine_mode)
		begin
			hi_nxt = on_sine;
			lo_nxt = !on_sine;
		end
		else if (drv.drive_en)
		begin
			hi_nxt = (rel < 3'h2) && on_blk;
			lo_nxt = (rel == 3'h3) || (rel == 3'h4);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			hi_out <= 1'b0;
			lo_out <= 1'b0;
		end
		else
		begin
			hi_out <= hi_nxt;
			lo_out <= lo_nxt;
		end
	end

	a_leg_no_overlap: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) !(hi_out && lo_out))
		else $error("both switches of one leg on");
endmodule // bsp_phase_gen

// ==== core/bsp_pkg.sv ====
// shared constants and types of the sine pwm motor sequencer
package bsp_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYC = CLK_MHZ * TICK_US;
	localparam int unsigned STOP_OFF_US = 1000;
	localparam int unsigned STOP_OFF_CYC = CLK_MHZ * STOP_OFF_US;
	localparam int unsigned ON_IGNORE_NS = 200;
	localparam int unsigned ON_IGNORE_CYC = ON_IGNORE_NS * CLK_MHZ / 1000;
	localparam int unsigned SINE_HZ = 1;
	localparam int unsigned SINE_MS = 1000 / SINE_HZ;
	localparam int unsigned RELEASE_MS = 2;
	localparam int unsigned TON_LONG_MS = 1000;
	localparam int unsigned TON_SHORT_MS = 500;
	localparam int unsigned TOFF_LONG_MS = 10000;
	localparam int unsigned TOFF_SHORT_MS = 5000;
	localparam int unsigned CAR0_HZ = 50_000;
	localparam int unsigned CAR1_HZ = 100_000;
	localparam int unsigned CAR2_HZ = 200_000;
	localparam int unsigned CAR3_HZ = 25_000;
	localparam logic [8:0] CAR0_CYC = 9'(CLK_HZ / CAR0_HZ);
	localparam logic [8:0] CAR1_CYC = 9'(CLK_HZ / CAR1_HZ);
	localparam logic [8:0] CAR2_CYC = 9'(CLK_HZ / CAR2_HZ);
	localparam logic [8:0] CAR3_CYC = 9'(CLK_HZ / CAR3_HZ);
	// duty is counted in 1/128 steps
	localparam logic [7:0] DUTY_FULL = 8'h80;
	localparam logic [7:0] MIN_BASE = 8'h0c;
	localparam logic [7:0] MIN_INC = 8'h02;
	localparam logic [7:0] START_CAP_HI = 8'h1a;
	localparam logic [7:0] START_CAP_LO = 8'h0e;
	// digitized command, full scale equals the 256 step reference
	localparam logic [7:0] ADC_LO = 8'h20;
	localparam logic [7:0] ADC_HI = 8'ha0;
	localparam logic [1:0] CMD_ANALOG = 2'h2;
	localparam logic [1:0] CMD_PULSE = 2'h1;
	localparam logic [1:0] LD_OFF_STEP = 2'h3;
	localparam logic [3:0] MIN_STEP_HI = 4'h8;
	localparam logic [7:0] PHASE_ANG = 8'h55;
	localparam logic [7:0] SECTOR_ANG = 8'h2b;
	localparam logic [5:0] SECTOR_STEPS = 6'h2a;
	localparam int unsigned STEP_SHIFT = 5;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_CAR_LSB = 2;
	localparam int unsigned CTRL_MIN_LSB = 4;
	localparam int unsigned CTRL_LD_LSB = 8;
	localparam int unsigned CTRL_TACHO_BIT = 10;
	localparam logic [10:0] CTRL_RESET = 11'h002;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_SINE,
		ST_LOCK_OFF,
		ST_FAULT
	} bsp_state_t;
endpackage

// ==== core/bsp_sequencer.sv ====
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
module bsp_sequencer
	import bsp_pkg::*;
#(
	parameter int unsigned TICK_CYC_P = TICK_CYC,
	parameter int unsigned STOP_CYC_P = STOP_OFF_CYC,
	parameter int unsigned WIN_LOG2   = 14
)
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	input  wire logic [2:0]  hall_in,
	input  wire logic        direction_in,
	input  wire logic        speed_command_in,
	input  wire logic [7:0]  speed_adc_in,
	input  wire logic        overcurrent_detect_in,
	input  wire logic        overtemp_detect_in,
	input  wire logic        overvoltage_detect_in,
	output logic [2:0]       phase_hi_out,
	output logic [2:0]       phase_lo_out,
	output logic             tacho_pulse_out,
	output logic             lock_indication_out
);
	logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic        awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, arrdy_r, arrdy_nxt;
	logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [7:0]  awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [3:0]  wstrb_r, wstrb_nxt;
	logic [10:0] ctrl_r, ctrl_nxt;
	logic [31:0] status;
	logic [1:0]  mode, car_step, ld_step;
	logic [3:0]  min_step;
	logic        tacho_ratio;
	logic [13:0] tick_cnt_r, tick_cnt_nxt;
	logic        tick_r, tick_nxt;
	logic [13:0] lo_run_r, lo_run_nxt;
	logic [1:0]  hi_run_r, hi_run_nxt;
	logic [WIN_LOG2-1:0] win_r, win_nxt, acc_r, acc_nxt;
	logic [7:0]  pulse_duty_r, pulse_duty_nxt, cmd_duty_r, cmd_duty_nxt;
	logic        pulse_run_r, pulse_run_nxt, cmd_run_r, cmd_run_nxt;
	logic [7:0]  adc_duty, acc_duty;
	bsp_state_t  st_r, st_nxt;
	logic [13:0] wms_r, wms_nxt, ton, toff;
	logic [10:0] rev_ms_r, rev_ms_nxt;
	logic [1:0]  zero_ms_r, zero_ms_nxt;
	logic        sine_ok_r, sine_ok_nxt, lock_ind_r, lock_ind_nxt;
	logic        tacho_r, tacho_nxt;
	logic [2:0]  hall_r, hall_nxt, sec_r, sec_nxt, sector;
	logic [7:0]  duty_r, duty_nxt, angle_r, angle_nxt, min_duty, start_duty;
	logic [19:0] sec_cyc_r, sec_cyc_nxt;
	logic [14:0] step_len_r, step_len_nxt, sub_r, sub_nxt;
	logic [5:0]  steps_r, steps_nxt;
	logic [8:0]  car_cnt_r, car_cnt_nxt, period;
	logic        hall_chg, fault_any, ld_fault;

	// register bus: write address and data taken in either order
	always_comb
	begin
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		ctrl_nxt = ctrl_r;
		if (s_axi_awvalid_in && awrdy_r)
		begin
			aw_have_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && wrdy_r)
		begin
			w_have_nxt = 1'b1;
			wdata_nxt = s_axi_wdata_in;
			wstrb_nxt = s_axi_wstrb_in;
		end
		if (bvalid_r && s_axi_bready_in)
			bvalid_nxt = 1'b0;
		if (aw_have_r && w_have_r && !bvalid_r)
		begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = RESP_OKAY;
			if (awaddr_r == REG_CTRL)
			begin
				if (wstrb_r[0])
					ctrl_nxt[7:0] = wdata_r[7:0];
				if (wstrb_r[1])
					ctrl_nxt[10:8] = wdata_r[10:8];
			end
			else if (awaddr_r != REG_STATUS)
				bresp_nxt = RESP_SLVERR;
		end
		if (rvalid_r && s_axi_rready_in)
			rvalid_nxt = 1'b0;
		if (s_axi_arvalid_in && arrdy_r)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = 32'h0;
			if (s_axi_araddr_in == REG_CTRL)
				rdata_nxt = {21'h0, ctrl_r};
			else if (s_axi_araddr_in == REG_STATUS)
				rdata_nxt = status;
			else
				rresp_nxt = RESP_SLVERR;
		end
		awrdy_nxt = !aw_have_nxt;
		wrdy_nxt = !w_have_nxt;
		arrdy_nxt = !rvalid_nxt;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 8'h0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0;
			ctrl_r <= CTRL_RESET;
			awrdy_r <= 1'b1;
			wrdy_r <= 1'b1;
			arrdy_r <= 1'b1;
		end
		else
		begin
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			ctrl_r <= ctrl_nxt;
			awrdy_r <= awrdy_nxt;
			wrdy_r <= wrdy_nxt;
			arrdy_r <= arrdy_nxt;
		end
	end

	assign s_axi_awready_out = awrdy_r;
	assign s_axi_wready_out = wrdy_r;
	assign s_axi_bvalid_out = bvalid_r;
	assign s_axi_bresp_out = bresp_r;
	assign s_axi_arready_out = arrdy_r;
	assign s_axi_rvalid_out = rvalid_r;
	assign s_axi_rresp_out = rresp_r;
	assign s_axi_rdata_out = rdata_r;
	assign status = {5'h0, sec_r, duty_r, cmd_duty_r, 2'h0,
		st_r == ST_SINE, lock_ind_r, st_r == ST_FAULT, 3'(st_r)};

	// step codes arrive already quantized
	assign mode = ctrl_r[CTRL_MODE_LSB +: 2];
	assign car_step = ctrl_r[CTRL_CAR_LSB +: 2];
	assign min_step = ctrl_r[CTRL_MIN_LSB +: 4];
	assign ld_step = ctrl_r[CTRL_LD_LSB +: 2];
	assign tacho_ratio = ctrl_r[CTRL_TACHO_BIT];

	// speed command decode and the 1 ms tick
	always_comb
	begin
		tick_nxt = (tick_cnt_r == 14'(TICK_CYC_P - 1));
		tick_cnt_nxt = tick_nxt ? 14'h0 : 14'(tick_cnt_r + 14'h1);
		adc_duty = (speed_adc_in <= ADC_LO) ? 8'h0
			: (speed_adc_in >= ADC_HI) ? DUTY_FULL
			: 8'(speed_adc_in - ADC_LO);
		hi_run_nxt = !speed_command_in ? 2'h0
			: (hi_run_r > 2'(ON_IGNORE_CYC)) ? hi_run_r
			: 2'(hi_run_r + 2'h1);
		lo_run_nxt = speed_command_in ? 14'h0
			: (lo_run_r >= 14'(STOP_CYC_P)) ? lo_run_r
			: 14'(lo_run_r + 14'h1);
		pulse_run_nxt = pulse_run_r;
		if (hi_run_r > 2'(ON_IGNORE_CYC))
			pulse_run_nxt = 1'b1;
		else if (lo_run_r >= 14'(STOP_CYC_P))
			pulse_run_nxt = 1'b0;
		win_nxt = WIN_LOG2'(win_r + 1'b1);
		acc_nxt = WIN_LOG2'(acc_r + speed_command_in);
		acc_duty = 8'(acc_r >> (WIN_LOG2 - 7));
		if (speed_command_in && (&acc_r))
			acc_duty = DUTY_FULL;
		pulse_duty_nxt = pulse_duty_r;
		if (&win_r)
		begin
			pulse_duty_nxt = acc_duty;
			acc_nxt = '0;
		end
		case (mode)
			CMD_ANALOG:
			begin
				cmd_run_nxt = speed_adc_in > ADC_LO;
				cmd_duty_nxt = adc_duty;
			end
			CMD_PULSE:
			begin
				cmd_run_nxt = pulse_run_r;
				cmd_duty_nxt = pulse_run_r ? pulse_duty_r : 8'h0;
			end
			default:
			begin
				cmd_run_nxt = 1'b0;
				cmd_duty_nxt = 8'h0;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			tick_cnt_r <= 14'h0;
			tick_r <= 1'b0;
			hi_run_r <= 2'h0;
			lo_run_r <= 14'h0;
			pulse_run_r <= 1'b0;
			win_r <= '0;
			acc_r <= '0;
			pulse_duty_r <= 8'h0;
			cmd_run_r <= 1'b0;
			cmd_duty_r <= 8'h0;
		end
		else
		begin
			tick_cnt_r <= tick_cnt_nxt;
			tick_r <= tick_nxt;
			hi_run_r <= hi_run_nxt;
			lo_run_r <= lo_run_nxt;
			pulse_run_r <= pulse_run_nxt;
			win_r <= win_nxt;
			acc_r <= acc_nxt;
			pulse_duty_r <= pulse_duty_nxt;
			cmd_run_r <= cmd_run_nxt;
			cmd_duty_r <= cmd_duty_nxt;
		end
	end

	always_comb
	begin
		case (hall_in)
			3'h1: sector = 3'h0;
			3'h3: sector = 3'h1;
			3'h2: sector = 3'h2;
			3'h6: sector = 3'h3;
			3'h4: sector = 3'h4;
			3'h5: sector = 3'h5;
			default: sector = 3'h7;
		endcase
		case (ld_step)
			2'h2:
			begin
				ton = 14'(TON_LONG_MS);
				toff = 14'(TOFF_LONG_MS);
			end
			2'h1:
			begin
				ton = 14'(TON_SHORT_MS);
				toff = 14'(TOFF_LONG_MS);
			end
			default:
			begin
				ton = 14'(TON_SHORT_MS);
				toff = 14'(TOFF_SHORT_MS);
			end
		endcase
		case (car_step)
			2'h3: period = CAR3_CYC;
			2'h2: period = CAR2_CYC;
			2'h1: period = CAR1_CYC;
			default: period = CAR0_CYC;
		endcase
	end

	// sequencer: startup, sine drive, lockout retry and fault hold
	always_comb
	begin
		hall_chg = hall_in != hall_r;
		fault_any = overcurrent_detect_in || overtemp_detect_in
			|| overvoltage_detect_in;
		ld_fault = overcurrent_detect_in || overtemp_detect_in;
		min_duty = (min_step != 4'h0 && min_step < MIN_STEP_HI)
			? 8'(MIN_BASE + 8'(min_step) * MIN_INC) : 8'h0;
		if (min_duty != 8'h0)
			start_duty = min_duty;
		else if (min_step == 4'h0)
			start_duty = (cmd_duty_r > START_CAP_LO) ? START_CAP_LO
				: cmd_duty_r;
		else
			start_duty = (cmd_duty_r > START_CAP_HI) ? START_CAP_HI
				: cmd_duty_r;
		hall_nxt = hall_in;
		sec_nxt = sector;
		st_nxt = st_r;
		wms_nxt = (tick_r && wms_r != 14'h3fff) ? 14'(wms_r + 14'h1) : wms_r;
		zero_ms_nxt = cmd_run_r ? 2'h0 : (tick_r && zero_ms_r != 2'h3)
			? 2'(zero_ms_r + 2'h1) : zero_ms_r;
		rev_ms_nxt = (tick_r && rev_ms_r != 11'h7ff)
			? 11'(rev_ms_r + 11'h1) : rev_ms_r;
		sine_ok_nxt = sine_ok_r && (rev_ms_r < 11'(SINE_MS));
		if (hall_in[0] && !hall_r[0])
		begin
			sine_ok_nxt = rev_ms_r < 11'(SINE_MS);
			rev_ms_nxt = 11'h0;
		end
		lock_ind_nxt = lock_ind_r;
		if (fault_any)
		begin
			st_nxt = ST_FAULT;
			if (ld_fault)
				lock_ind_nxt = 1'b0;
		end
		else
			case (st_r)
				ST_IDLE:
					if (cmd_run_r)
					begin
						st_nxt = ST_START;
						wms_nxt = 14'h0;
					end
				ST_START, ST_SINE:
					if (!cmd_run_r)
						st_nxt = ST_IDLE;
					else if (hall_chg)
					begin
						wms_nxt = 14'h0;
						st_nxt = sine_ok_r ? ST_SINE : ST_START;
					end
					else if (ld_step != LD_OFF_STEP && wms_r >= ton)
					begin
						st_nxt = ST_LOCK_OFF;
						wms_nxt = 14'h0;
						lock_ind_nxt = 1'b0;
					end
					else if (!sine_ok_r)
						st_nxt = ST_START;
				ST_LOCK_OFF:
					if (!cmd_run_r)
						st_nxt = ST_IDLE;
					else if (wms_r >= toff)
					begin
						st_nxt = ST_START;
						wms_nxt = 14'h0;
					end
				ST_FAULT:
					if (zero_ms_r >= 2'(RELEASE_MS))
						st_nxt = ST_IDLE;
				default:
					st_nxt = ST_IDLE;
			endcase
		// raised only while sine drive goes on, so a lockout from sine shows
		if (st_nxt == ST_SINE && !ld_fault)
			lock_ind_nxt = 1'b1;
		case (st_r)
			ST_START: duty_nxt = start_duty;
			ST_SINE: duty_nxt = (cmd_duty_r < min_duty) ? min_duty
				: cmd_duty_r;
			default: duty_nxt = 8'h0;
		endcase
		// rotor angle estimate between hall edges
		sec_cyc_nxt = (&sec_cyc_r) ? sec_cyc_r : 20'(sec_cyc_r + 20'h1);
		sub_nxt = 15'(sub_r + 15'h1);
		step_len_nxt = step_len_r;
		steps_nxt = steps_r;
		angle_nxt = angle_r;
		if (hall_chg && sector != 3'h7)
		begin
			angle_nxt = 8'(8'(sector) * SECTOR_ANG
				+ (direction_in ? SECTOR_ANG : 8'h0));
			step_len_nxt = 15'(sec_cyc_r >> STEP_SHIFT);
			sec_cyc_nxt = 20'h0;
			sub_nxt = 15'h0;
			steps_nxt = 6'h0;
		end
		else if (sub_r >= step_len_r)
		begin
			sub_nxt = 15'h0;
			if (steps_r < SECTOR_STEPS)
			begin
				steps_nxt = 6'(steps_r + 6'h1);
				angle_nxt = direction_in ? 8'(angle_r - 8'h1)
					: 8'(angle_r + 8'h1);
			end
		end
		tacho_nxt = tacho_ratio ? (tacho_r ^ hall_chg)
			: hall_in[0];
		car_cnt_nxt = (car_cnt_r >= 9'(period - 9'h1)) ? 9'h0
			: 9'(car_cnt_r + 9'h1);
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			st_r <= ST_IDLE;
			hall_r <= 3'h0;
			sec_r <= 3'h7;
			wms_r <= 14'h0;
			zero_ms_r <= 2'h0;
			rev_ms_r <= 11'h7ff;
			sine_ok_r <= 1'b0;
			lock_ind_r <= 1'b1;
			duty_r <= 8'h0;
			sec_cyc_r <= 20'h0;
			sub_r <= 15'h0;
			step_len_r <= 15'h0;
			steps_r <= 6'h0;
			angle_r <= 8'h0;
			tacho_r <= 1'b0;
			car_cnt_r <= 9'h0;
		end
		else
		begin
			st_r <= st_nxt;
			hall_r <= hall_nxt;
			sec_r <= sec_nxt;
			wms_r <= wms_nxt;
			zero_ms_r <= zero_ms_nxt;
			rev_ms_r <= rev_ms_nxt;
			sine_ok_r <= sine_ok_nxt;
			lock_ind_r <= lock_ind_nxt;
			duty_r <= duty_nxt;
			sec_cyc_r <= sec_cyc_nxt;
			sub_r <= sub_nxt;
			step_len_r <= step_len_nxt;
			steps_r <= steps_nxt;
			angle_r <= angle_nxt;
			tacho_r <= tacho_nxt;
			car_cnt_r <= car_cnt_nxt;
		end
	end

	assign tacho_pulse_out = tacho_r;
	assign lock_indication_out = lock_ind_r;

	bsp_drive_if drv ();
	assign drv.sector = sec_r;
	assign drv.angle = angle_r;
	assign drv.duty = duty_r;
	assign drv.car_cnt = car_cnt_r;
	assign drv.car_period = period;
	assign drv.sine_mode = st_r == ST_SINE;
	assign drv.drive_en = (st_r == ST_START || st_r == ST_SINE)
		&& sec_r != 3'h7;
	assign drv.reverse = direction_in;

	for (genvar g = 0; g < 3; g++)
	begin : g_leg
		bsp_phase_gen #(.PHASE(g)) u_leg (
			.clk_in   (clk_in),
			.rst_n_in (rst_n_in),
			.drv      (drv),
			.hi_out   (phase_hi_out[g]),
			.lo_out   (phase_lo_out[g])
		);
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_fault_stops_drive: assert property (fault_any |=> st_r == ST_FAULT
		##1 phase_hi_out == 3'h0)
		else $error("drive not stopped after fault");
	a_fault_lock_low: assert property (ld_fault |=> !lock_ind_r)
		else $error("lock output not low after fault");
	a_min_step_start: assert property (st_r == ST_START && min_step != 4'h0
		&& min_step < MIN_STEP_HI && !fault_any |=> duty_r
		== 8'(MIN_BASE + 8'($past(min_step)) * MIN_INC))
		else $error("startup duty differs from step duty");
	a_step8_start: assert property (st_r == ST_START
		&& min_step == 4'h8
		|=> duty_r == (($past(cmd_duty_r) > START_CAP_HI) ? START_CAP_HI
		: $past(cmd_duty_r)))
		else $error("step 8 startup duty not the lesser value");
	a_step0_start: assert property (st_r == ST_START
		&& min_step == 4'h0
		|=> duty_r == (($past(cmd_duty_r) > START_CAP_LO) ? START_CAP_LO
		: $past(cmd_duty_r)))
		else $error("step 0 startup duty not the lesser value");
	a_lock_window: assert property (st_r == ST_START && !fault_any
		&& cmd_run_r && !hall_chg && ld_step != LD_OFF_STEP && wms_r >= ton
		|=> st_r == ST_LOCK_OFF ##1 phase_hi_out == 3'h0)
		else $error("no lockout after drive window");
	a_off_cancel: assert property (st_r == ST_LOCK_OFF && !cmd_run_r
		&& !fault_any |=> st_r == ST_IDLE)
		else $error("zero command did not cancel off window");
	a_analog_map: assert property (mode == CMD_ANALOG && speed_adc_in >= ADC_HI
		|=> cmd_duty_r == DUTY_FULL && cmd_run_r)
		else $error("full command not full duty");
	a_tacho_three: assert property (tacho_ratio && hall_chg
		|=> tacho_pulse_out != $past(tacho_pulse_out))
		else $error("tacho missed a hall change");
	// a shorter period may leave the count above it for one cycle
	a_carrier_wrap: assert property ($stable(period)
		|-> car_cnt_r < period)
		else $error("carrier count beyond period");
endmodule // bsp_sequencer

// ==== verif/bsp_hall_model.sv ====
// hall sensor model: rotor steps one sector per period while run is high
module bsp_hall_model
#(
	parameter int unsigned PER = 100
)
(
	input  wire logic  clk_in,
	input  wire logic  run_in,
	input  wire logic  rev_in,
	output logic [2:0] hall_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] hcode [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
	int         cnt = 0;
	int         sec = 0;
	always @(posedge clk_in)
	begin
		cnt <= (run_in && cnt < PER - 1) ? cnt + 1 : 0;
		if (run_in && cnt == PER - 1)
			sec <= rev_in ? (sec + 5) % 6 : (sec + 1) % 6;
	end
	assign hall_out = hcode[sec];
endmodule // bsp_hall_model

// ==== verif/tb_bldc_sine_pwm_sequencer.sv ====
// self-checking bench of the sine pwm motor sequencer
module tb_bldc_sine_pwm_sequencer import bsp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_in = 0, rst_n_in = 0, awv = 0, wv = 0, bready = 0;
	logic        arv = 0, rready = 0, dir = 0, run = 0, oc = 0;
	logic        cmd = 0, pwm_en = 0, ot = 0, ov = 0;
	logic [2:0]  pc = 3'h0, hiw = 3'h4;
	logic [3:0]  strb = 4'hf;
	logic        awr, wr, bv, arr, rv, tacho, lock;
	logic [7:0]  ad = 8'h00, adc = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd, seed = 32'h000165f3;
	logic [1:0]  bresp, rresp, rr;
	logic [2:0]  hall, ph_hi, ph_lo;
	int          fail_count = 0, checks = 0;
	initial forever #50 clk_in = ~clk_in;
	bsp_sequencer #(.TICK_CYC_P(10), .STOP_CYC_P(20), .WIN_LOG2(8))
		i_bsp_sequencer (.clk_in, .rst_n_in, .s_axi_awaddr_in(ad),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(bready), .s_axi_araddr_in(ad), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rready), .hall_in(hall), .direction_in(dir),
		.speed_command_in(cmd), .speed_adc_in(adc),
		.overcurrent_detect_in(oc), .overtemp_detect_in(ot),
		.overvoltage_detect_in(ov), .phase_hi_out(ph_hi),
		.phase_lo_out(ph_lo), .tacho_pulse_out(tacho),
		.lock_indication_out(lock));
	bsp_hall_model #(.PER(100)) i_bsp_hall_model (.clk_in, .run_in(run),
		.rev_in(dir), .hall_out(hall));
	// 8 cycle command period: 1.25 MHz against the 10 cycle bench tick
	always @(posedge clk_in)
	begin
		pc <= pc + 3'h1;
		cmd <= pwm_en && pc < hiw;
	end
	task automatic stop_test();
		if (fail_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic [7:0] cmdd(input logic [7:0] a);
		return a <= 8'h20 ? 8'h00 : a >= 8'ha0 ? 8'h80 : a - 8'h20;
	endfunction
	function automatic int carhz(input int s);
		return s == 3 ? 25_000 : s == 2 ? 200_000 : s == 1 ? 100_000 : 50_000;
	endfunction
	function automatic logic [7:0] exps(input logic [3:0] m,
		input logic [7:0] c);
		logic [7:0] cp = m == 4'h0 ? 8'h0e : 8'h1a;
		if (m inside {[1:7]})
			return 8'h0c + 8'h02 * m;
		return c > cp ? cp : c;
	endfunction
	// one aligned word over the register bus, write when w is high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		logic got = 0;
		ad <= a;
		wdata <= d;
		awv <= w;
		wv <= w;
		bready <= w;
		arv <= !w;
		rready <= !w;
		for (int n = 0; n < 50 && !got; n++)
		begin
			@(posedge clk_in);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
			if (arr) arv <= 1'b0;
			got = w ? bv : rv;
			rd = rdata;
			rr = rresp;
		end
		bready <= 1'b0;
		rready <= 1'b0;
		// an edge between transfers, so no strobe is assigned twice at once
		@(posedge clk_in);
		chk(32'(got), 32'h1);
		if (!got) stop_test();
	endtask
	task automatic st();
		xfer(1'b0, REG_STATUS, 32'h0);
	endtask
	task automatic cnt_rise(input logic hi, input int cyc, output int e);
		logic p = hi ? ph_hi[0] : tacho;
		e = 0;
		repeat (cyc)
		begin
			@(posedge clk_in);
			e += int'((hi ? ph_hi[0] : tacho) && !p);
			p = hi ? ph_hi[0] : tacho;
		end
	endtask
	initial
	begin
		int e;
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		xfer(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h002);
		strb <= 4'h1;
		xfer(1'b1, REG_CTRL, 32'h7fc);
		strb <= 4'hf;
		adc <= 8'h60;
		xfer(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h0fc);
		repeat (8) @(posedge clk_in);
		st();
		chk(32'(rd[2:0]), 32'h0);
		xfer(1'b0, 8'h0c, 32'h0);
		chk(32'(rr), 32'(RESP_SLVERR));
		for (int k = 0; k < 10; k++)
		begin
			seed = xs(seed);
			adc <= 8'h20;
			xfer(1'b1, REG_CTRL, 32'(32'h302 | k << 4 | k % 4 << 2));
			st();
			chk(32'(rd[2:0]), 32'h0);
			adc <= k == 0 ? 8'h2e : k == 8 ? 8'h3a : 8'h21 + seed[7:0] % 8'hdf;
			// long enough for the carrier count to wrap at its new period
			repeat (400) @(posedge clk_in);
			st();
			chk(32'(rd[2:0]), 32'h1);
			chk(32'(rd[15:8]), 32'(cmdd(adc)));
			e = int'(exps(k[3:0], cmdd(adc)));
			chk(32'(rd[23:16]), e);
			cnt_rise(1'b1, 1200, e);
			chk(32'(e), 1200 * carhz(k % 4) / CLK_HZ);
		end
		adc <= 8'h00;
		xfer(1'b1, REG_CTRL, 32'h002);
		adc <= 8'h60;
		repeat (4900) @(posedge clk_in);
		st();
		chk(32'(rd[2:0]), 32'h1);
		repeat (200) @(posedge clk_in);
		st();
		chk(32'(rd[2:0]), 32'h3);
		chk(32'(lock), 32'h0);
		adc <= 8'h00;
		// zero command held well past the release time
		repeat (40) @(posedge clk_in);
		st();
		chk(32'(rd[2:0]), 32'h0);
		dir <= seed[0];
		run <= 1'b1;
		adc <= 8'h60;
		repeat (3000) @(posedge clk_in);
		st();
		chk(32'(rd[2:0]), 32'h2);
		chk(32'(lock), 32'h1);
		cnt_rise(1'b0, 2400, e);
		chk(32'(e), 32'h4);
		xfer(1'b1, REG_CTRL, 32'h402);
		cnt_rise(1'b0, 2400, e);
		chk(32'(e), 32'hc);
		oc <= 1'b1;
		repeat (10) @(posedge clk_in);
		st();
		chk(32'(rd[2:0]), 32'h4);
		chk(32'({lock, ph_hi}), 32'h0);
		oc <= 1'b0;
		adc <= 8'h00;
		repeat (40) @(posedge clk_in);
		st();
		chk(32'(rd[2:0]), 32'h0);
		// pulse command: two cycle highs are ignored, four cycle highs run
		xfer(1'b1, REG_CTRL, 32'h301);
		hiw <= 3'h2;
		pwm_en <= 1'b1;
		repeat (300) @(posedge clk_in);
		st();
		chk(32'(rd[2:0]), 32'h0);
		hiw <= 3'h4;
		repeat (600) @(posedge clk_in);
		st();
		chk(32'(rd[2:0]), 32'h2);
		chk(32'(rd[15:8] inside {8'h3f, 8'h40}), 32'h1);
		ov <= 1'b1;
		repeat (10) @(posedge clk_in);
		st();
		chk(32'({rd[2:0], lock, ph_hi}), 32'h48);
		ot <= 1'b1;
		repeat (10) @(posedge clk_in);
		chk(32'(lock), 32'h0);
		ot <= 1'b0;
		ov <= 1'b0;
		pwm_en <= 1'b0;
		repeat (60) @(posedge clk_in);
		st();
		chk(32'(rd[2:0]), 32'h0);
		stop_test();
	end
endmodule // tb_bldc_sine_pwm_sequencer
